// *** core/sie_pkg.sv ***
/*
  shared constants and carrier types for the scsi interrupt status and enable block.
  assumes a byte-wide register port and one core clock.
*/
package sie_pkg;
  localparam logic [7:0] SIE_EVT_MASK_ADDR  = 8'h40;
  localparam logic [7:0] SIE_TMR_MASK_ADDR  = 8'h41;
  localparam logic [7:0] SIE_EVT_FLAGS_ADDR = 8'h42;
  localparam logic [7:0] SIE_TMR_FLAGS_ADDR = 8'h43;
  localparam logic [7:0] SIE_SUMMARY_ADDR   = 8'h14;
  localparam logic [7:0] SIE_CFG_ADDR       = 8'h50;
  localparam logic [7:0] SIE_EVT_MASK_RST   = 8'h00;
  localparam logic [2:0] SIE_TMR_MASK_RST   = 3'h0;
  localparam logic [7:0] SIE_FLAGS_RST      = 8'h00;
  localparam logic [7:0] SIE_CFG_RST        = 8'h00;
  localparam int         SIE_TMR_W          = 3;
  // event flag bit positions
  localparam int SIE_B_MA  = 7;
  localparam int SIE_B_CMP = 6;
  localparam int SIE_B_SEL = 5;
  localparam int SIE_B_RSL = 4;
  localparam int SIE_B_SGE = 3;
  localparam int SIE_B_UDC = 2;
  localparam int SIE_B_RST = 1;
  localparam int SIE_B_PAR = 0;
  // timer flag bit positions
  localparam int SIE_B_STO = 2;
  localparam int SIE_B_GEN = 1;
  localparam int SIE_B_HTH = 0;
  // summary bits
  localparam int SIE_B_SIP = 1;
  localparam int SIE_B_DIP = 0;
  // configuration bits
  localparam int SIE_B_TARGET   = 0;
  localparam int SIE_B_LOWLEVEL = 1;
  localparam int SIE_B_SEL_EN   = 2;
  localparam int SIE_B_RSL_EN   = 3;
  localparam int SIE_B_PAR_EN   = 4;
  localparam int SIE_B_PAR_THRU = 5;
  // minimum spacing of status reads in core clocks
  localparam int SIE_READ_GAP   = 12;

  typedef struct packed {
    logic phase_mismatch;
    logic atn_seen;
    logic phase_change;
    logic arb_sel_done;
    logic selected;
    logic reselected;
    logic fifo_underflow;
    logic fifo_overflow;
    logic zero_offset_ack;
    logic offset_exceeded;
    logic residual_start;
    logic phase_chg_offset;
    logic target_drop;
    logic any_drop;
    logic bus_rst_level;
    logic scsi_par_err;
    logic host_par_err;
  } sie_events_t;

  typedef struct packed {
    logic sel_timeout;
    logic gp_expired;
    logic hs_expired;
  } sie_timers_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sie_req_t;
endpackage

// *** core/sie_irq.sv ***
/*
  scsi interrupt status, mask, stacking and pending summary logic.
  assumes events and timers are pulses on core_clk, except bus_rst_level which is a level
  from the bus pin and is synchronised here.
*/
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Operation
// R1: timer mask bits 2..0 gate timeout conditions onto irq; flags still set
// R2: cleared timer mask bit never stops pending summary from setting
// R3: irq stays latched until the status register is read; unmasking keeps it
// R4: masking an occurred non-fatal condition clears pending and releases stack
// R5: masked non-fatal never blocks others; stacking starts once a summary flag sets
// R6: software programs masks at init and does not toggle them later
// R7: selection timeout sets its flag
// R8: after arbitration work continues until interrupt; software flushes fifo on timeout
// R9: general timer expiry sets its flag
// R10: handshake gap timeout sets its flag
// R11: event flags read regardless of mask; read clears bits seen, stacked appear later
// R12: reading timer flags clears the whole register
// R13: pending summary clears only after both status registers are read
// R14: software spaces consecutive status reads by twelve clocks
// R15: software reads both scsi status registers before dma status
// R16: bit 7 on phase mismatch, target atn, or low level phase change
// R17: bit 6 when arbitration and selection completed
// R18: bits 5 and 4 on selection or reselection when response enabled
// R19: gross error on fifo, offset, residual or phase-with-offset faults
// R20: bit 2 on unexpected drop as initiator, any drop low level, or timeout
// R21: bit 1 on rising edge of bus reset, once per assertion
// R22: bit 0 on parity error when checking enabled; host side only pass-through (code flags host side only when pass-through is off)
// R23: selected, reselected, complete and target atn are the non-fatal conditions
// R24: reserved timer mask and flag bits ignore writes and read zero
module sie_irq
  import sie_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire sie_req_t    req,
  output logic      [7:0]  rdata,
  input  wire sie_events_t evt,
  input  wire sie_timers_t tmr,
  input  wire logic        dma_pending,
  output logic             irq
);

  logic [7:0] evt_mask_r;
  logic [2:0] tmr_mask_r;
  logic [7:0] cfg_r;
  logic [7:0] evt_flags_r;
  logic [7:0] evt_flags_nxt;
  logic [2:0] tmr_flags_r;
  logic [2:0] tmr_flags_nxt;
  typedef enum {
    SIE_RD_IDLE,
    SIE_RD_EVT,
    SIE_RD_TMR
  } sie_rd_state_t;

  sie_rd_state_t rd_state_r;
  logic [7:0] evt_bypass;
  logic       release_all;
  logic       both_read;
  logic       sip_r;
  logic       irq_r;
  logic [7:0] rdata_r;
  logic       rst_s1_r;
  logic       rst_s2_r;
  logic       rst_d_r;
  logic [7:0] evt_set;
  logic [2:0] tmr_set;
  logic [7:0] nonfatal;
  logic       stacking;
  logic       rd_evt;
  logic       rd_tmr;
  logic       wr_evt_mask;
  logic       wr_tmr_mask;
  logic       target;
  logic       lowlvl;

  assign target      = cfg_r[SIE_B_TARGET];
  assign lowlvl      = cfg_r[SIE_B_LOWLEVEL];
  assign rd_evt      = req.rd && req.addr == SIE_EVT_FLAGS_ADDR;
  assign rd_tmr      = req.rd && req.addr == SIE_TMR_FLAGS_ADDR;
  assign wr_evt_mask = req.wr && req.addr == SIE_EVT_MASK_ADDR;
  assign wr_tmr_mask = req.wr && req.addr == SIE_TMR_MASK_ADDR;

  // bus reset pin synchroniser and edge detect
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
      rst_d_r  <= 1'b0;
    end else begin
      rst_s1_r <= evt.bus_rst_level;
      rst_s2_r <= rst_s1_r;
      rst_d_r  <= rst_s2_r;
    end
  end

  // raw condition decode
  always_comb begin
    evt_set = 8'h00;
    evt_set[SIE_B_MA] = (!target && evt.phase_mismatch) || (target && evt.atn_seen)
                        || (lowlvl && evt.phase_change); // R16
    evt_set[SIE_B_CMP] = evt.arb_sel_done; // R17
    evt_set[SIE_B_SEL] = evt.selected && cfg_r[SIE_B_SEL_EN]; // R18
    evt_set[SIE_B_RSL] = evt.reselected && cfg_r[SIE_B_RSL_EN]; // R18
    evt_set[SIE_B_SGE] = evt.fifo_underflow || evt.fifo_overflow
                         || (target && evt.zero_offset_ack) || evt.offset_exceeded
                         || evt.residual_start
                         || (!target && evt.phase_chg_offset); // R19
    evt_set[SIE_B_UDC] = (!target && evt.target_drop) || (lowlvl && evt.any_drop)
                         || tmr.sel_timeout; // R20
    evt_set[SIE_B_RST] = rst_s2_r && !rst_d_r; // R21
    evt_set[SIE_B_PAR] = cfg_r[SIE_B_PAR_EN] && (evt.scsi_par_err
                         || (!cfg_r[SIE_B_PAR_THRU] && evt.host_par_err)); // R22
    tmr_set = 3'h0;
    tmr_set[SIE_B_STO] = tmr.sel_timeout; // R7
    tmr_set[SIE_B_GEN] = tmr.gp_expired; // R9
    tmr_set[SIE_B_HTH] = tmr.hs_expired; // R10
  end

  always_comb begin
    nonfatal = 8'h00;
    nonfatal[SIE_B_SEL] = 1'b1; // R23
    nonfatal[SIE_B_RSL] = 1'b1; // R23
    nonfatal[SIE_B_CMP] = 1'b1; // R23
    nonfatal[SIE_B_MA]  = target; // R23
  end

  // stacking is live while a summary flag is up
  assign stacking = sip_r || dma_pending; // R5

  // masked non-fatal conditions neither raise the summary nor wait in the stack
  assign evt_bypass = nonfatal & ~evt_mask_r; // R5

  // masking a visible non-fatal with nothing else up drops the summary, frees the stack
  assign release_all = wr_evt_mask && |(evt_flags_r & nonfatal & ~req.wdata)
                       && !(|(evt_flags_r & ~nonfatal)) && !(|tmr_flags_r); // R4

  // event and timer flag banks
  sie_flag_bank #(
    .WIDTH       (8)
  ) evt_bank_u (
    .core_clk    (core_clk),
    .reset       (reset),
    .set         (evt_set),
    .rd          (rd_evt), // R11
    .stacking    (stacking),
    .bypass      (evt_bypass),
    .release_all (release_all),
    .flags       (evt_flags_r),
    .flags_nxt   (evt_flags_nxt)
  );

  sie_flag_bank #(
    .WIDTH       (SIE_TMR_W)
  ) tmr_bank_u (
    .core_clk    (core_clk),
    .reset       (reset),
    .set         (tmr_set),
    .rd          (rd_tmr), // R12
    .stacking    (stacking),
    .bypass      (3'h0),
    .release_all (release_all),
    .flags       (tmr_flags_r),
    .flags_nxt   (tmr_flags_nxt)
  );

  // pending summary: set by any flag but a masked non-fatal one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sip_r <= 1'b0;
    end else if (release_all) begin
      sip_r <= 1'b0; // R4
    end else if (|(evt_flags_nxt & ~evt_bypass) || |tmr_flags_nxt) begin
      sip_r <= 1'b1; // R2
    end else if (both_read) begin
      sip_r <= 1'b0; // R13
    end
  end

  // irq latch: set by any unmasked flag, released only by a status read
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else if (|(evt_flags_nxt & evt_mask_r) || |(tmr_flags_nxt & tmr_mask_r)) begin
      irq_r <= 1'b1; // R1 R8
    end else if (rd_evt || rd_tmr) begin
      irq_r <= 1'b0; // R3
    end
  end

  // the read that completes the pair of status reads clears the summary
  assign both_read = (rd_state_r == SIE_RD_EVT && rd_tmr)
                     || (rd_state_r == SIE_RD_TMR && rd_evt); // R13

  // which status register has been read since the summary rose
  always_ff @(posedge core_clk) begin
    if (reset || !sip_r) begin
      rd_state_r <= SIE_RD_IDLE;
    end else begin
      case (rd_state_r)
        SIE_RD_IDLE: begin
          if (rd_evt) begin
            rd_state_r <= SIE_RD_EVT;
          end else if (rd_tmr) begin
            rd_state_r <= SIE_RD_TMR;
          end
        end
        SIE_RD_EVT: begin
          if (rd_tmr) begin
            rd_state_r <= SIE_RD_IDLE;
          end
        end
        SIE_RD_TMR: begin
          if (rd_evt) begin
            rd_state_r <= SIE_RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= SIE_RD_IDLE;
        end
      endcase
    end
  end

  // mask and configuration registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      evt_mask_r <= SIE_EVT_MASK_RST;
      tmr_mask_r <= SIE_TMR_MASK_RST;
      cfg_r      <= SIE_CFG_RST;
    end else begin
      if (wr_evt_mask) begin
        evt_mask_r <= req.wdata;
      end
      if (wr_tmr_mask) begin
        tmr_mask_r <= req.wdata[SIE_TMR_W-1:0]; // R24
      end
      if (req.wr && req.addr == SIE_CFG_ADDR) begin
        cfg_r <= req.wdata;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        SIE_EVT_MASK_ADDR:  rdata_r <= evt_mask_r;
        SIE_TMR_MASK_ADDR:  rdata_r <= {5'h00, tmr_mask_r}; // R24
        SIE_EVT_FLAGS_ADDR: rdata_r <= evt_flags_r; // R11
        SIE_TMR_FLAGS_ADDR: rdata_r <= {5'h00, tmr_flags_r}; // R24
        SIE_SUMMARY_ADDR:   rdata_r <= {6'h00, sip_r, dma_pending};
        SIE_CFG_ADDR:       rdata_r <= cfg_r;
        default:            rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign irq   = irq_r;

endmodule

// one bank of read-to-clear flags with a stack behind it
module sie_flag_bank
  import sie_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic             rd,
  input  wire logic             stacking,
  input  wire logic [WIDTH-1:0] bypass,
  input  wire logic             release_all,
  output logic      [WIDTH-1:0] flags,
  output logic      [WIDTH-1:0] flags_nxt
);

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] stack_r;
  logic [WIDTH-1:0] stack_nxt;

  // a read hands the stack over; a condition in the read cycle still lands, set wins
  always_comb begin
    flags_nxt = flags_r;
    stack_nxt = stack_r;
    if (rd) begin
      flags_nxt = stack_r | set; // R11
      stack_nxt = '0;
    end else if (stacking) begin
      flags_nxt = flags_r | (set & (flags_r | bypass)); // R5
      stack_nxt = stack_r | (set & ~flags_r & ~bypass); // R5
    end else begin
      flags_nxt = flags_r | stack_r | set; // R5
      stack_nxt = '0;
    end
    if (release_all) begin
      flags_nxt = flags_nxt | stack_nxt; // R4
      stack_nxt = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_r <= SIE_FLAGS_RST[WIDTH-1:0];
      stack_r <= SIE_FLAGS_RST[WIDTH-1:0];
    end else begin
      flags_r <= flags_nxt;
      stack_r <= stack_nxt;
    end
  end

  assign flags = flags_r;

endmodule

// *** test/sie_bus_model.sv ***
/* far-side scsi devices: raise bus conditions and timer expiries.
   assumes the bench selects conditions one cycle ahead on pick. */
`timescale 1ns/1ps
module sie_bus_model
  import sie_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [19:0] pick,
  output sie_events_t      evt,
  output sie_timers_t      tmr
);
  initial {evt, tmr} = '0;
  // each picked condition shows one cycle later, reset line as a level
  always @(posedge core_clk) begin
    {evt, tmr} <= pick;
  end
endmodule

// *** test/sie_irq_chk.sv ***
/* port assertions for the scsi interrupt block.
   assumes a bind to sie_irq and one core clock. */
`timescale 1ns/1ps
module sie_irq_chk
  import sie_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire sie_req_t    req,
  input wire logic [7:0]  rdata,
  input wire sie_events_t evt,
  input wire sie_timers_t tmr,
  input wire logic        dma_pending,
  input wire logic        irq
);
  logic [7:0] em_r;
  logic [2:0] tm_r;
  logic       rd_r;
  logic [7:0] ad_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // mirror of last read and mask writes
  always_ff @(posedge core_clk) begin
    rd_r <= req.rd & ~reset;
    ad_r <= req.addr;
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      em_r <= 8'h00;
      tm_r <= 3'h0;
    end else if (req.wr && req.addr == SIE_EVT_MASK_ADDR) begin
      em_r <= req.wdata;
    end else if (req.wr && req.addr == SIE_TMR_MASK_ADDR) begin
      tm_r <= req.wdata[2:0];
    end
  end
  a_rdata_idle: assert property (!rd_r |-> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_unmapped_zero: assert property
    (rd_r && !(ad_r inside {[8'h40:8'h43], 8'h14, 8'h50}) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_tmask_read: assert property (rd_r && ad_r == 8'h41 |-> rdata == {5'h00, tm_r})
    else $error("timer mask readback wrong");
  a_emask_read: assert property (rd_r && ad_r == 8'h40 |-> rdata == em_r)
    else $error("event mask readback wrong");
  a_tflag_resv: assert property (rd_r && ad_r == 8'h43 |-> rdata[7:3] == 5'h00)
    else $error("timer flag reserved bits set");
  a_tmr_irq: assert property ((tmr & tm_r) != 3'h0 && !req.rd |=> irq)
    else $error("unmasked timer without irq");
  a_evt_irq: assert property (evt.arb_sel_done && em_r[6] && !req.rd |=> irq)
    else $error("unmasked completion without irq");
  a_irq_latched: assert property
    (irq && !(req.rd && req.addr inside {8'h42, 8'h43}) |=> irq)
    else $error("irq dropped without status read");
  a_summary_dma: assert property (rd_r && ad_r == 8'h14 |-> rdata[0] == $past(dma_pending))
    else $error("dma pending summary wrong");
  c_irq_up: cover property ($rose(irq));
  c_flag_read: cover property (rd_r && ad_r == 8'h42 && rdata != 8'h00);
  c_tmr_masked: cover property (tmr != 3'h0 && tm_r == 3'h0);
endmodule

// *** test/testbench.sv ***
/* self-checking bench for the scsi interrupt block.
   assumes sie_bus_model as far side and the checker bound below. */
`timescale 1ns/1ps
module testbench;
  import sie_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  sie_req_t    req = '0;
  logic [7:0]  rdata;
  sie_events_t evt;
  sie_timers_t tmr;
  logic        dma_pending = 1'b0;
  logic        irq;
  logic [19:0] pick = '0;
  int          errors = 0;
  int          total_checks = 0;
  // pick bit, configuration, expected event flags
  logic [23:0] tbl [20] = '{24'h130080, 24'h120180, 24'h110280, 24'h100040, 24'h0f0420,
    24'h0f0000, 24'h0e0810, 24'h0d0008, 24'h0c0008, 24'h0b0108, 24'h0a0008, 24'h090008,
    24'h080008, 24'h070004, 24'h070100, 24'h060204, 24'h041001, 24'h040000, 24'h031001,
    24'h033000};
  always #5 core_clk = ~core_clk;
  sie_bus_model far_u (.core_clk(core_clk), .pick(pick), .evt(evt), .tmr(tmr));
  sie_irq dut_u (.core_clk(core_clk), .reset(reset), .req(req), .rdata(rdata), .evt(evt),
    .tmr(tmr), .dma_pending(dma_pending), .irq(irq));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e & m, rdata & m);
    repeat (12) @(posedge core_clk);
  endtask
  task automatic fire(input logic [19:0] p);
    @(posedge core_clk);
    pick <= p;
    @(posedge core_clk);
    pick <= '0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset();
    logic [7:0] al [7] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h14, 8'h50, 8'h7f};
    foreach (al[i]) rd(al[i], 8'h00, 8'hff);
    wr(8'h41, 8'hff);
    rd(8'h41, 8'h07, 8'hff);
    wr(8'h43, 8'hff);
    rd(8'h43, 8'h00, 8'hff);
    wr(8'h41, 8'h00);
  endtask
  task automatic t_masked_tmr();
    fire(20'h2);
    chk("irq", 8'h00, {7'h00, irq});
    rd(8'h14, 8'h02, 8'hff);
    rd(8'h43, 8'h02, 8'hff);
    rd(8'h43, 8'h00, 8'hff);
    rd(8'h14, 8'h02, 8'hff);
    rd(8'h42, 8'h00, 8'hff);
    rd(8'h14, 8'h00, 8'hff);
  endtask
  task automatic t_timers();
    wr(8'h41, 8'h07);
    for (int i = 0; i < 3; i++) begin
      fire(20'h1 << i);
      chk("irq", 8'h01, {7'h00, irq});
      if (i == 0) wr(8'h41, 8'h00);
      if (i == 0) chk("irq", 8'h01, {7'h00, irq});
      rd(8'h43, 8'h01 << i, 8'hff);
      rd(8'h42, (i == 2) ? 8'h04 : 8'h00, 8'hff);
      chk("irq", 8'h00, {7'h00, irq});
      if (i == 0) wr(8'h41, 8'h07);
    end
    rd(8'h42, 8'h00, 8'h00);
    rd(8'h43, 8'h00, 8'hff);
    wr(8'h41, 8'h00);
  endtask
  task automatic t_events();
    foreach (tbl[i]) begin
      wr(8'h50, tbl[i][15:8]);
      fire(20'h1 << tbl[i][20:16]);
      rd(8'h42, tbl[i][7:0], 8'hff);
      rd(8'h43, 8'h00, 8'hff);
    end
    wr(8'h50, 8'h04);
    fire(20'h1 << 15);
    rd(8'h14, 8'h00, 8'hff);
    rd(8'h42, 8'h20, 8'hff);
    rd(8'h43, 8'h00, 8'hff);
  endtask
  task automatic t_busrst();
    @(posedge core_clk);
    pick <= 20'h20;
    repeat (10) @(posedge core_clk);
    rd(8'h42, 8'h02, 8'hff);
    rd(8'h42, 8'h00, 8'hff);
    pick <= '0;
    rd(8'h43, 8'h00, 8'hff);
  endtask
  task automatic t_stack();
    wr(8'h40, 8'hff);
    fire(20'h1 << 16);
    fire(20'h1 << 13);
    rd(8'h42, 8'h40, 8'hff);
    chk("irq", 8'h01, {7'h00, irq});
    rd(8'h43, 8'h00, 8'hff);
    rd(8'h42, 8'h08, 8'hff);
    rd(8'h43, 8'h00, 8'hff);
    chk("irq", 8'h00, {7'h00, irq});
  endtask
  task automatic t_nonfatal();
    wr(8'h40, 8'h40);
    fire(20'h1 << 16);
    wr(8'h40, 8'h00);
    rd(8'h14, 8'h00, 8'hff);
    chk("irq", 8'h01, {7'h00, irq});
    rd(8'h42, 8'h40, 8'hff);
    chk("irq", 8'h00, {7'h00, irq});
    wr(8'h40, 8'h40);
    fire(20'h1 << 16);
    fire(20'h1 << 13);
    wr(8'h40, 8'h00);
    rd(8'h42, 8'h48, 8'hff);
    rd(8'h43, 8'h00, 8'hff);
    chk("irq", 8'h00, {7'h00, irq});
    dma_pending <= 1'b1;
    rd(8'h14, 8'h01, 8'hff);
    fire(20'h1 << 13);
    rd(8'h14, 8'h01, 8'hff);
    dma_pending <= 1'b0;
    rd(8'h14, 8'h02, 8'hff);
    rd(8'h42, 8'h08, 8'hff);
    rd(8'h43, 8'h00, 8'hff);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_masked_tmr();
    t_timers();
    t_events();
    t_busrst();
    t_stack();
    t_nonfatal();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    test_done();
  end
endmodule
bind sie_irq sie_irq_chk chk_u (.core_clk(core_clk), .reset(reset), .req(req), .rdata(rdata),
  .evt(evt), .tmr(tmr), .dma_pending(dma_pending), .irq(irq));
